// ### verilog/ubl_baud_lin.sv
// Purpose: baud timer with fractional divider and lin header auto-baud
// Assumes: rxd already synchronous to clk; one clock domain
// Notes: measured reload is written into the reload register itself
//
// The address-and-strobe port and the address map were decided locally.
module ubl_baud_lin
  import ubl_pkg::*;
#(
  parameter int MW = 20
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [UBL_AW-1:0] addr,
  input  wire logic [UBL_DW-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [UBL_DW-1:0] rdata,
  input  wire logic              rxd,
  output logic                   os_tick,
  output logic                   bit_tick,
  output logic                   lin_synced,
  output logic                   frame_start,
  output logic                   sync_done
);

  function automatic logic hit(input logic [UBL_AW-1:0] a, input logic [UBL_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // register and baud timer state
  ubl_ctrl_t           ctrl_q, ctrl_d;
  logic [7:0]          reload_q, reload_d;
  logic [7:0]          step_q, step_d;
  logic [6:0]          pre_q, pre_d;
  logic [7:0]          tmr_q, tmr_d;
  logic [7:0]          acc_q, acc_d;
  logic [3:0]          osc_q, osc_d;
  logic                os_q, os_d;
  logic                bit_q, bit_d;
  logic [UBL_DW-1:0]   rdata_q, rdata_d;
  logic                err_q, err_d;
  // lin state
  ubl_state_t          st_q, st_d;
  logic                rxd_q;
  logic [MW-1:0]       brk_q, brk_d;
  logic [MW-1:0]       meas_q, meas_d;
  logic [2:0]          falls_q, falls_d;
  logic [7:0]          low_q, low_d;
  logic                synced_q, synced_d;
  logic                fstart_q, fstart_d;
  logic                sdone_q, sdone_d;
  // cross-group terms
  logic [6:0]          pre_lim;
  logic                pre_tick;
  logic [7:0]          eff_rel;
  logic                adopt;
  logic [7:0]          adopt_val;
  logic                lin_err;
  logic                fall;
  logic                rise;
  logic [MW-1:0]       quot;
  logic [MW+3:0]       brk_x8;
  logic [MW+3:0]       brk_need;
  logic [8:0]          acc_sum;

  assign pre_lim  = 7'((8'h01 << ctrl_q.presc) - 8'h01);
  assign pre_tick = (pre_q == pre_lim);
  // a single-clock divide would beat clk/32, so the 1x1 setting runs as 1x2
  assign eff_rel  = (ctrl_q.presc == 3'h0 && reload_q == 8'h00) ? 8'h01 : reload_q;
  assign fall     = rxd_q & ~rxd;
  assign rise     = ~rxd_q & rxd;
  assign acc_sum  = {1'b0, acc_q} + {1'b0, step_q};

  // baud and register group
  always_comb begin
    ctrl_d   = ctrl_q;
    reload_d = reload_q;
    step_d   = step_q;
    pre_d    = pre_q;
    tmr_d    = tmr_q;
    acc_d    = acc_q;
    osc_d    = osc_q;
    os_d     = 1'b0;
    bit_d    = 1'b0;
    err_d    = err_q;
    rdata_d  = '0;
    if (wr) begin
      if (hit(addr, UBL_OFS_CTRL)) begin
        ctrl_d = ubl_ctrl_t'(wdata);
      end else if (hit(addr, UBL_OFS_RELOAD)) begin
        reload_d = wdata;
      end else if (hit(addr, UBL_OFS_STEP)) begin
        step_d = wdata;
      end else if (hit(addr, UBL_OFS_STATUS)) begin
        if (wdata[UBL_STAT_ERR]) begin
          err_d = 1'b0;
        end
      end
    end
    // set beats a clear in the same cycle
    if (lin_err) begin
      err_d = 1'b1;
    end
    if (rd) begin
      if (hit(addr, UBL_OFS_CTRL)) begin
        rdata_d = ctrl_q;
      end else if (hit(addr, UBL_OFS_RELOAD)) begin
        rdata_d = reload_q;
      end else if (hit(addr, UBL_OFS_STEP)) begin
        rdata_d = step_q;
      end else if (hit(addr, UBL_OFS_STATUS)) begin
        rdata_d = {3'h0, err_q, synced_q, st_q};
      end else if (hit(addr, UBL_OFS_BRKLEN)) begin
        rdata_d = brk_q[MW-1 -: 8];
      end
    end
    if (!ctrl_q.run) begin
      pre_d = '0;
      tmr_d = eff_rel;
      acc_d = '0;
      osc_d = '0;
    end else if (pre_tick) begin
      pre_d = '0;
      if (tmr_q == 8'h00) begin
        tmr_d = eff_rel;
        if (ctrl_q.frac_en) begin
          // carry of an 8-bit accumulator passes step of every 256 expiries
          acc_d = acc_sum[7:0];
          os_d  = acc_sum[8];
        end else begin
          os_d = 1'b1;
        end
      end else begin
        tmr_d = tmr_q - 8'h01;
      end
    end else begin
      pre_d = pre_q + 7'h01;
    end
    if (os_d) begin
      osc_d = osc_q + 4'h1;
      bit_d = (osc_q == UBL_OS_LAST);
    end
    // restart the timer phase on the new rate at the synch byte's last falling edge
    if (adopt) begin
      reload_d = adopt_val;
      pre_d    = '0;
      tmr_d    = adopt_val;
      os_d     = 1'b0;
      bit_d    = 1'b0;
      acc_d    = '0;
      osc_d    = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q   <= ubl_ctrl_t'(UBL_CTRL_RST);
      reload_q <= UBL_RELOAD_RST;
      step_q   <= UBL_STEP_RST;
      pre_q    <= '0;
      tmr_q    <= '0;
      acc_q    <= '0;
      osc_q    <= '0;
      os_q     <= 1'b0;
      bit_q    <= 1'b0;
      err_q    <= 1'b0;
      rdata_q  <= '0;
    end else begin
      ctrl_q   <= ctrl_d;
      reload_q <= reload_d;
      step_q   <= step_d;
      pre_q    <= pre_d;
      tmr_q    <= tmr_d;
      acc_q    <= acc_d;
      osc_q    <= osc_d;
      os_q     <= os_d;
      bit_q    <= bit_d;
      err_q    <= err_d;
      rdata_q  <= rdata_d;
    end
  end

  // measurement in prescaled counts: 8 bits at 16 ticks each is 2^7 per tick step
  assign quot     = (meas_q + (ctrl_q.frac_en ? MW'(UBL_SYNC_ROUND) : '0)) >> UBL_SYNC_SHIFT;
  assign brk_x8   = {1'b0, brk_q, 3'b000};
  assign brk_need = (MW+4)'(UBL_BRK_BITS) * {4'h0, meas_q};

  // lin group
  always_comb begin
    st_d      = st_q;
    brk_d     = brk_q;
    meas_d    = meas_q;
    falls_d   = falls_q;
    low_d     = low_q;
    synced_d  = synced_q;
    fstart_d  = 1'b0;
    sdone_d   = 1'b0;
    adopt     = 1'b0;
    adopt_val = 8'h00;
    lin_err   = 1'b0;
    case (st_q)
      UBL_IDLE: begin
        synced_d = 1'b0;
        if (ctrl_q.lin_en) begin
          st_d = UBL_INIT;
        end
      end
      UBL_INIT: begin
        brk_d    = '0;
        meas_d   = '0;
        falls_d  = '0;
        low_d    = '0;
        synced_d = 1'b0;
        st_d     = UBL_WAIT;
      end
      UBL_WAIT: begin
        if (fall) begin
          brk_d = '0;
        end else if (!rxd && pre_tick && brk_q != '1) begin
          brk_d = brk_q + MW'(1);
        end
        if (rise && brk_q != '0) begin
          st_d     = UBL_SYNC;
          meas_d   = '0;
          falls_d  = '0;
          synced_d = 1'b0;
        end
      end
      UBL_SYNC: begin
        if ((falls_q != 3'h0 || fall) && pre_tick) begin
          meas_d = meas_q + MW'(1);
        end
        if (meas_q == '1) begin
          lin_err = 1'b1;
          st_d    = UBL_WAIT;
          brk_d   = '0;
        end else if (fall) begin
          falls_d = falls_q + 3'h1;
          if (falls_q == 3'(UBL_SYNC_FALLS)) begin
            // the break is judged in units of the measured host bit
            if (brk_x8 < brk_need || quot[MW-1:8] != '0 || quot == '0) begin
              lin_err = 1'b1;
              st_d    = UBL_WAIT;
              brk_d   = '0;
            end else begin
              adopt     = 1'b1;
              adopt_val = quot[7:0] - 8'h01;
              synced_d  = 1'b1;
              sdone_d   = 1'b1;
              st_d      = UBL_ALIGN;
            end
          end
        end
      end
      UBL_ALIGN: begin
        // stop bit rises, the next fall is the identifier's start bit
        if (rxd_q && fall) begin
          fstart_d = 1'b1;
          low_d    = '0;
          brk_d    = '0;
          st_d     = UBL_FRAME;
        end
      end
      UBL_FRAME: begin
        if (fall) begin
          low_d = '0;
          brk_d = '0;
        end else if (!rxd) begin
          if (os_q && low_q != '1) begin
            low_d = low_q + 8'h01;
          end
          if (pre_tick && brk_q != '1) begin
            brk_d = brk_q + MW'(1);
          end
        end
        // a next header whose break runs over 10 bits at the current rate forces a fresh measurement
        if (rise && low_q > UBL_FRAME_LOW) begin
          st_d     = UBL_SYNC;
          meas_d   = '0;
          falls_d  = '0;
          synced_d = 1'b0;
        end
      end
      default: begin
        st_d = UBL_IDLE;
      end
    endcase
    if (!ctrl_q.lin_en) begin
      st_d     = UBL_IDLE;
      synced_d = 1'b0;
      adopt    = 1'b0;
      lin_err  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q     <= UBL_IDLE;
      rxd_q    <= 1'b1;
      brk_q    <= '0;
      meas_q   <= '0;
      falls_q  <= '0;
      low_q    <= '0;
      synced_q <= 1'b0;
      fstart_q <= 1'b0;
      sdone_q  <= 1'b0;
    end else begin
      st_q     <= st_d;
      rxd_q    <= rxd;
      brk_q    <= brk_d;
      meas_q   <= meas_d;
      falls_q  <= falls_d;
      low_q    <= low_d;
      synced_q <= synced_d;
      fstart_q <= fstart_d;
      sdone_q  <= sdone_d;
    end
  end

  assign rdata       = rdata_q;
  assign os_tick     = os_q;
  assign bit_tick    = bit_q;
  assign lin_synced  = synced_q;
  assign frame_start = fstart_q;
  assign sync_done   = sdone_q;

endmodule

// ### verilog/ubl_pkg.sv
// Purpose: constants and types for the baud generator with lin auto-baud
// Assumes: 8-bit register port, one clock, rxd synchronous to clk
// Notes: register offsets are word indices on the plain register port
package ubl_pkg;
  localparam int         UBL_AW         = 3;
  localparam int         UBL_DW         = 8;
  localparam logic [2:0] UBL_OFS_CTRL   = 3'h0;
  localparam logic [2:0] UBL_OFS_RELOAD = 3'h1;
  localparam logic [2:0] UBL_OFS_STEP   = 3'h2;
  localparam logic [2:0] UBL_OFS_STATUS = 3'h3;
  localparam logic [2:0] UBL_OFS_BRKLEN = 3'h4;
  localparam logic [7:0] UBL_CTRL_RST   = 8'h00;
  localparam logic [7:0] UBL_RELOAD_RST = 8'h00;
  localparam logic [7:0] UBL_STEP_RST   = 8'h00;
  localparam int         UBL_STAT_ERR   = 4;
  // 16 ticks per bit times 8 bits of synch byte is 2^7 prescaled counts
  localparam int         UBL_SYNC_SHIFT = 7;
  localparam int         UBL_SYNC_ROUND = 64;
  localparam int         UBL_BRK_BITS   = 13;
  localparam int         UBL_SYNC_FALLS = 4;
  localparam logic [3:0] UBL_OS_LAST    = 4'hF;
  // a low run over 10 bits cannot be a character, so it is a break
  localparam logic [7:0] UBL_FRAME_LOW  = 8'hA0;

  typedef struct packed {
    logic       rsvd;
    logic       run;
    logic       lin_en;
    logic       frac_en;
    logic       rsvd2;
    logic [2:0] presc;
  } ubl_ctrl_t;

  typedef enum logic [2:0] {
    UBL_IDLE  = 3'b000,
    UBL_INIT  = 3'b001,
    UBL_WAIT  = 3'b010,
    UBL_SYNC  = 3'b011,
    UBL_ALIGN = 3'b100,
    UBL_FRAME = 3'b101
  } ubl_state_t;
endpackage

// ### verification/ubl_baud_lin_asserts.sv
// Purpose: port-level checks for the baud generator
// Assumes: one clock, rst async active high
// Notes: pulses are one cycle wide
module ubl_baud_lin_asserts
  import ubl_pkg::*;
#(
  parameter int MW = 20
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [UBL_AW-1:0] addr,
  input wire logic [UBL_DW-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [UBL_DW-1:0] rdata,
  input wire logic              rxd,
  input wire logic              os_tick,
  input wire logic              bit_tick,
  input wire logic              lin_synced,
  input wire logic              frame_start,
  input wire logic              sync_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_sync;
    sync_done ##1 !sync_done;
  endsequence
  property p_tick_gap;
    os_tick |=> !os_tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("os tick too dense");
  property p_bit_os;
    bit_tick |-> os_tick;
  endproperty
  a_bit_os: assert property (p_bit_os) else $error("bit tick without os tick");
  property p_bit_one;
    bit_tick |=> !bit_tick [*8];
  endproperty
  a_bit_one: assert property (p_bit_one) else $error("bit ticks too close");
  property p_rd_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_sync_lvl;
    sync_done |-> ##[0:1] lin_synced;
  endproperty
  a_sync_lvl: assert property (p_sync_lvl) else $error("no sync level");
  property p_fs_sync;
    frame_start |-> lin_synced && !sync_done;
  endproperty
  a_fs_sync: assert property (p_fs_sync) else $error("frame before sync");
  property p_sd_one;
    sync_done |-> s_sync;
  endproperty
  a_sd_one: assert property (p_sd_one) else $error("sync pulse long");
  property p_fs_one;
    frame_start |=> !frame_start;
  endproperty
  a_fs_one: assert property (p_fs_one) else $error("frame pulse long");
endmodule

bind ubl_baud_lin ubl_baud_lin_asserts #(.MW(MW)) u_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .rxd(rxd), .os_tick(os_tick), .bit_tick(bit_tick),
  .lin_synced(lin_synced), .frame_start(frame_start), .sync_done(sync_done)
);

// ### verification/ubl_lin_host.sv
// Purpose: lin master model driving the serial line
// Assumes: bit time given in clocks per call
// Notes: line idles recessive high, pulled up
module ubl_lin_host (
  input wire logic clk,
  output logic     rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd = 1'b1;
  task bits(input logic v, input int n);
    rxd <= v;
    repeat (n) @(posedge clk);
  endtask
  task send_byte(input logic [7:0] b, input int bc);
    bits(1'b0, bc);
    for (int i = 0; i < 8; i++) bits(b[i], bc);
    bits(1'b1, bc);
  endtask
  // brk below 13 only when a refusal is wanted
  task send_header(input int brk, input int bc, input logic [7:0] pid);
    bits(1'b0, brk * bc);
    bits(1'b1, bc);
    send_byte(8'h55, bc);
    send_byte(pid, bc);
  endtask
endmodule

// ### verification/tb.sv
// Purpose: self-checking bench for the baud generator
// Assumes: 200 MHz clock, reset held 10 cycles
// Notes: reads are checked from a queue by a monitor
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ubl_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [UBL_AW-1:0] addr = '0;
  logic [UBL_DW-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              rd_d = 1'b0;
  logic [UBL_DW-1:0] rdata;
  logic              rxd;
  logic              os_tick, bit_tick, lin_synced, frame_start, sync_done;
  logic [UBL_DW-1:0] exp_q[$];
  int                failures = 0;
  int                total_checks = 0;
  int                sd_n = 0;
  int                fs_n = 0;
  int                r;
  always #2.5 clk = ~clk;
  ubl_baud_lin #(.MW(20)) u_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxd(rxd), .os_tick(os_tick), .bit_tick(bit_tick),
    .lin_synced(lin_synced), .frame_start(frame_start), .sync_done(sync_done)
  );
  ubl_lin_host u_host (.clk(clk), .rxd(rxd));
  task chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      failures++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  always @(posedge clk) begin
    rd_d <= rd;
    if (sd_n >= 0 && sync_done === 1'b1) sd_n++;
    if (frame_start === 1'b1) fs_n++;
    if (rd_d === 1'b1) chk(exp_q.size() > 0 && rdata === exp_q.pop_front(), "read");
  end
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd_reg(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // first gap after a write may be cut short, so the second is judged
  task gap(output int n, input logic s);
    repeat (2) begin
      n = 0;
      @(posedge clk iff (s ? bit_tick : os_tick) === 1'b1);
      do begin
        @(posedge clk);
        n++;
      end while ((s ? bit_tick : os_tick) !== 1'b1 && n < 3000);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    complete_run;
  end
  initial begin
    int n;
    void'($urandom(89));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(UBL_OFS_CTRL, UBL_CTRL_RST);
    rd_reg(UBL_OFS_RELOAD, UBL_RELOAD_RST);
    rd_reg(UBL_OFS_STEP, UBL_STEP_RST);
    rd_reg(3'h7, 8'h00);
    $display("test regs done");
    for (int p = 0; p < 3; p++) begin
      r = 1 + $urandom % 7;
      wr_reg(UBL_OFS_RELOAD, 8'(r));
      wr_reg(UBL_OFS_CTRL, 8'h40 | 8'(p));
      gap(n, 1'b0);
      chk(n == (1 << p) * (r + 1), "tick period");
    end
    wr_reg(UBL_OFS_RELOAD, 8'h00);
    wr_reg(UBL_OFS_CTRL, 8'h40);
    gap(n, 1'b0);
    chk(n == 2, "capped period");
    $display("test divider done");
    wr_reg(UBL_OFS_RELOAD, 8'h01);
    wr_reg(UBL_OFS_STEP, 8'h80);
    wr_reg(UBL_OFS_CTRL, 8'h50);
    gap(n, 1'b0);
    chk(n == 4, "fractional period");
    gap(n, 1'b1);
    chk(n == 64, "bit period");
    $display("test fraction done");
    wr_reg(UBL_OFS_RELOAD, 8'h00);
    wr_reg(UBL_OFS_CTRL, 8'h60);
    u_host.send_header(14, 64, 8'h3C);
    chk(sd_n == 1 && fs_n == 1 && lin_synced === 1'b1, "first header");
    rd_reg(UBL_OFS_RELOAD, 8'h03);
    rd_reg(UBL_OFS_STATUS, 8'h0D);
    u_host.send_header(14, 128, 8'h3C);
    chk(sd_n == 2 && fs_n == 2, "second header");
    rd_reg(UBL_OFS_RELOAD, 8'h07);
    $display("test lin done");
    wr_reg(UBL_OFS_CTRL, 8'h40);
    rd_reg(UBL_OFS_STATUS, 8'h00);
    wr_reg(UBL_OFS_CTRL, 8'h60);
    u_host.send_header(10, 64, 8'h3C);
    chk(sd_n == 2 && lin_synced === 1'b0, "short break synced");
    rd_reg(UBL_OFS_STATUS, 8'h13);
    wr_reg(UBL_OFS_STATUS, 8'h10);
    rd_reg(UBL_OFS_STATUS, 8'h03);
    $display("test break done");
    repeat (4) @(posedge clk);
    chk(exp_q.size() == 0, "reads missing");
    complete_run;
  end
endmodule
